/* mcc_pkg.sv */
// Shared constants and types for the main clock and time-base controller
package mcc_pkg;

   localparam int ADDR_W    = 10;
   localparam int DATA_W    = 32;
   localparam int TB_CNT_W  = 18;
   localparam int TONE_W    = 14;
   localparam int PR_W      = 4;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL    = 8'h2C;
   localparam logic [7:0] IDX_TONE    = 8'h2D;
   localparam logic [7:0] IDX_IRQ_ST  = 8'h30;
   localparam logic [7:0] IDX_IRQ_MSK = 8'h31;

   // Control/status field positions
   localparam int B_MCO  = 7;
   localparam int CP_LSB = 5;
   localparam int B_SMS  = 4;
   localparam int TB_LSB = 2;
   localparam int B_OIE  = 1;
   localparam int B_OIF  = 0;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] TONE_RST = 2'h0;
   localparam logic [1:0] TONE_OFF = 2'h0;

   // Time-base periods in oscillator cycles
   localparam int TB_PERIOD0 = 16000;
   localparam int TB_PERIOD1 = 32000;
   localparam int TB_PERIOD2 = 80000;
   localparam int TB_PERIOD3 = 200000;

   // Tone half periods in oscillator cycles at 8 MHz
   localparam int TONE_HALF1 = 2000;
   localparam int TONE_HALF2 = 4000;
   localparam int TONE_HALF3 = 8000;

   typedef enum logic [2:0] {
      PM_RUN     = 3'b001,
      PM_ACTHALT = 3'b010,
      PM_HALT    = 3'b100
   } pm_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [DATA_W-1:0] prdata;
   } apb_rsp_t;

   typedef struct packed {
      logic [7:0]          ctrl;
      logic [1:0]          toneSel;
      logic                irqSt;
      logic                irqMsk;
      logic [TB_CNT_W-1:0] tbCnt;
      logic [1:0]          tbSel;
      logic [PR_W-1:0]     prCnt;
      logic                cpuEn;
      logic                clkOut;
      logic [TONE_W-1:0]   toneCnt;
      logic                tone;
      pm_t                 pm;
      logic [DATA_W-1:0]   prdata;
      logic                pslverr;
   } state_t;

endpackage

/* main_clock_rtc_controller.sv */
// Main clock prescaler, clock-out, time-base timer and tone generator
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Slow select clear runs at oscillator rate; set applies divider.
// - Divider codes 00..11 divide by 2, 4, 8 and 16.
// - Clock-out enable drives the clock onto the alternate pin.
// - Clock-out disabled releases the pin, no clock driven.
// - Clock-out stops toggling during active-halt.
// - Period codes give 16000, 32000, 80000 or 200000 cycles.
// - New period setting applies only after the running period ends.
// - Period elapsed flag sets each time the period ends.
// - Reading the control/status register in run mode clears the elapsed flag.
// - Period interrupt needs enable set and CPU mask inactive.
// - Halt with period interrupt enabled enters active-halt instead.
// - Wait mode changes nothing; the interrupt wakes the chip.
// - Active-halt runs counter, freezes registers; interrupt wakes.
// - Full halt freezes counter and registers; only other sources wake.
// - Tone register selects one of three tones on the tone pin.
// - Tone codes: off, about 2 kHz, 1 kHz, 500 Hz, half duty.
module main_clock_rtc_controller #(
   parameter int TB_PERIOD0 = mcc_pkg::TB_PERIOD0,
   parameter int TB_PERIOD1 = mcc_pkg::TB_PERIOD1,
   parameter int TB_PERIOD2 = mcc_pkg::TB_PERIOD2,
   parameter int TB_PERIOD3 = mcc_pkg::TB_PERIOD3,
   parameter int TONE_HALF1 = mcc_pkg::TONE_HALF1,
   parameter int TONE_HALF2 = mcc_pkg::TONE_HALF2,
   parameter int TONE_HALF3 = mcc_pkg::TONE_HALF3
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              clkEn,
   input  wire mcc_pkg::apb_req_t apbReq,
   output var  mcc_pkg::apb_rsp_t apbRsp,
   input  wire logic              haltReq,
   input  wire logic              wakeOther,
   input  wire logic              cpuIrqMask,
   output logic                   cpuClkEn,
   output logic                   periodIrq,
   output logic                   irq,
   output logic                   activeHalt,
   output logic                   fullHalt,
   output logic                   clkOutO,
   output logic                   clkOutOe,
   output logic                   toneO,
   output logic                   toneOe
);
   import mcc_pkg::*;

   if (TB_PERIOD0 < 2 || TB_PERIOD3 >= (1 << TB_CNT_W) ||
       TB_PERIOD1 < 2 || TB_PERIOD2 < 2 ||
       TB_PERIOD1 >= (1 << TB_CNT_W) || TB_PERIOD2 >= (1 << TB_CNT_W)) begin
      $error("time-base period out of range");
   end
   if (TONE_HALF1 < 1 || TONE_HALF2 < 1 || TONE_HALF3 < 1 ||
       TONE_HALF3 >= (1 << TONE_W) || TONE_HALF2 >= (1 << TONE_W) ||
       TONE_HALF1 >= (1 << TONE_W)) begin
      $error("tone half period out of range");
   end

   localparam logic [TB_CNT_W-1:0] TB_LAST0 = TB_CNT_W'(TB_PERIOD0 - 1);
   localparam logic [TB_CNT_W-1:0] TB_LAST1 = TB_CNT_W'(TB_PERIOD1 - 1);
   localparam logic [TB_CNT_W-1:0] TB_LAST2 = TB_CNT_W'(TB_PERIOD2 - 1);
   localparam logic [TB_CNT_W-1:0] TB_LAST3 = TB_CNT_W'(TB_PERIOD3 - 1);
   localparam logic [TONE_W-1:0]   TN_LAST1 = TONE_W'(TONE_HALF1 - 1);
   localparam logic [TONE_W-1:0]   TN_LAST2 = TONE_W'(TONE_HALF2 - 1);
   localparam logic [TONE_W-1:0]   TN_LAST3 = TONE_W'(TONE_HALF3 - 1);
   localparam logic [PR_W-1:0]     PR_ONE   = PR_W'(1);

   function automatic logic [TB_CNT_W-1:0] tbLast(input logic [1:0] sel);
      logic [TB_CNT_W-1:0] r;
      r = TB_LAST0;
      case (sel)
         2'h1: r = TB_LAST1;
         2'h2: r = TB_LAST2;
         2'h3: r = TB_LAST3;
         default: r = TB_LAST0;
      endcase
      return r;
   endfunction

   function automatic logic [TONE_W-1:0] toneLast(input logic [1:0] sel);
      logic [TONE_W-1:0] r;
      r = TN_LAST1;
      case (sel)
         2'h2: r = TN_LAST2;
         2'h3: r = TN_LAST3;
         default: r = TN_LAST1;
      endcase
      return r;
   endfunction

   state_t s_ff;
   state_t nxt_s;

   logic                setup;
   logic                access;
   logic                hitCtrl;
   logic                hitTone;
   logic                hitSt;
   logic                hitMsk;
   logic                regsLive;
   logic                tbEnd;
   logic                rdClr;
   logic                w1c;
   logic                oieNow;
   logic [1:0]          cpSel;
   logic [PR_W-1:0]     prLast;

   assign setup    = apbReq.psel & ~apbReq.penable;
   assign access   = apbReq.psel & apbReq.penable;
   assign regsLive = (s_ff.pm == PM_RUN);
   assign oieNow   = s_ff.ctrl[B_OIE];
   assign cpSel    = s_ff.ctrl[CP_LSB +: 2];
   // Ratio 2 << code, minus one
   assign prLast   = PR_W'((PR_ONE << ({1'b0, cpSel} + 3'h1)) - PR_ONE);

   always_comb begin
      hitCtrl = 1'b0;
      hitTone = 1'b0;
      hitSt   = 1'b0;
      hitMsk  = 1'b0;
      if (apbReq.paddr == {IDX_CTRL, 2'b00}) begin
         hitCtrl = 1'b1;
      end else if (apbReq.paddr == {IDX_TONE, 2'b00}) begin
         hitTone = 1'b1;
      end else if (apbReq.paddr == {IDX_IRQ_ST, 2'b00}) begin
         hitSt = 1'b1;
      end else if (apbReq.paddr == {IDX_IRQ_MSK, 2'b00}) begin
         hitMsk = 1'b1;
      end
   end

   assign rdClr = access & ~apbReq.pwrite & hitCtrl & regsLive;
   assign w1c   = access & apbReq.pwrite & hitSt & apbReq.pwdata[0];

   always_comb begin
      nxt_s = s_ff;
      tbEnd = 1'b0;

      // Time base runs except in full halt
      if (s_ff.pm != PM_HALT) begin
         if (s_ff.tbCnt == tbLast(s_ff.tbSel)) begin
            nxt_s.tbCnt = '0;
            tbEnd       = 1'b1;
            nxt_s.tbSel = s_ff.ctrl[TB_LSB +: 2];
         end else begin
            nxt_s.tbCnt = s_ff.tbCnt + TB_CNT_W'(1);
         end
      end

      // Set wins over the read clear
      nxt_s.ctrl[B_OIF] = tbEnd | (s_ff.ctrl[B_OIF] & ~rdClr);
      nxt_s.irqSt       = tbEnd | (s_ff.irqSt & ~w1c);

      // Control, tone and mask writes are frozen outside run mode
      if (access && apbReq.pwrite && regsLive) begin
         if (hitCtrl) begin
            nxt_s.ctrl[7:1] = apbReq.pwdata[7:1];
         end else if (hitTone) begin
            nxt_s.toneSel = apbReq.pwdata[1:0];
         end else if (hitMsk) begin
            nxt_s.irqMsk = apbReq.pwdata[0];
         end
      end

      // Read data and error captured in the setup cycle
      if (setup) begin
         nxt_s.prdata  = '0;
         nxt_s.pslverr = ~(hitCtrl | hitTone | hitSt | hitMsk);
         if (hitCtrl) begin
            nxt_s.prdata[7:0] = s_ff.ctrl;
         end else if (hitTone) begin
            nxt_s.prdata[1:0] = s_ff.toneSel;
         end else if (hitSt) begin
            nxt_s.prdata[0] = s_ff.irqSt;
         end else if (hitMsk) begin
            nxt_s.prdata[0] = s_ff.irqMsk;
         end
      end

      // CPU clock enable; wait mode needs no special handling
      if (s_ff.pm != PM_RUN) begin
         nxt_s.cpuEn = 1'b0;
         nxt_s.prCnt = '0;
      end else if (!s_ff.ctrl[B_SMS]) begin
         nxt_s.cpuEn = 1'b1;
         nxt_s.prCnt = '0;
      end else if (s_ff.prCnt >= prLast) begin
         nxt_s.cpuEn = 1'b1;
         nxt_s.prCnt = '0;
      end else begin
         nxt_s.cpuEn = 1'b0;
         nxt_s.prCnt = s_ff.prCnt + PR_ONE;
      end

      // Clock-out follows CPU clock, held in active-halt
      if (!s_ff.ctrl[B_MCO]) begin
         nxt_s.clkOut = 1'b0;
      end else if (s_ff.pm == PM_RUN && s_ff.cpuEn) begin
         nxt_s.clkOut = ~s_ff.clkOut;
      end

      // Tone generator keeps running in active-halt
      if (s_ff.toneSel == TONE_OFF) begin
         nxt_s.toneCnt = '0;
         nxt_s.tone    = 1'b0;
      end else if (s_ff.pm != PM_HALT) begin
         if (s_ff.toneCnt >= toneLast(s_ff.toneSel)) begin
            nxt_s.toneCnt = '0;
            nxt_s.tone    = ~s_ff.tone;
         end else begin
            nxt_s.toneCnt = s_ff.toneCnt + TONE_W'(1);
         end
      end

      // Power mode tracking
      case (s_ff.pm)
         PM_RUN: begin
            if (haltReq) begin
               nxt_s.pm = oieNow ? PM_ACTHALT : PM_HALT;
            end
         end
         PM_ACTHALT: begin
            if (periodIrq || wakeOther) begin
               nxt_s.pm = PM_RUN;
            end
         end
         PM_HALT: begin
            if (wakeOther) begin
               nxt_s.pm = PM_RUN;
            end
         end
         default: nxt_s.pm = PM_RUN;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_ff         <= '0;
         s_ff.ctrl    <= CTRL_RST;
         s_ff.toneSel <= TONE_RST;
         s_ff.pm      <= PM_RUN;
      end else if (clkEn) begin
         s_ff <= nxt_s;
      end
   end

   assign periodIrq = s_ff.ctrl[B_OIF] & oieNow & ~cpuIrqMask;
   assign irq        = s_ff.irqSt & s_ff.irqMsk;
   assign cpuClkEn   = s_ff.cpuEn;
   assign activeHalt = (s_ff.pm == PM_ACTHALT);
   assign fullHalt   = (s_ff.pm == PM_HALT);
   assign clkOutO    = s_ff.clkOut;
   assign clkOutOe   = s_ff.ctrl[B_MCO];
   assign toneO      = s_ff.tone;
   assign toneOe     = (s_ff.toneSel != TONE_OFF);

   assign apbRsp.pready  = access;
   assign apbRsp.pslverr = access & s_ff.pslverr;
   assign apbRsp.prdata  = s_ff.prdata;

   default clocking cb @(posedge mclk iff clkEn);
   endclocking
   default disable iff (!rstn);

   sequence s_div2;
      !cpuClkEn ##1 cpuClkEn;
   endsequence

   sequence s_stayRunDiv2;
      s_ff.pm == PM_RUN && s_ff.ctrl[B_SMS] && cpSel == 2'h0;
   endsequence

   a_normal_rate: assert property (
      (s_ff.pm == PM_RUN && !s_ff.ctrl[B_SMS] && !haltReq) |=> cpuClkEn)
      else $error("cpu enable missing in normal mode");

   a_slow_div2: assert property (
      (cpuClkEn && !haltReq && !access) ##0 s_stayRunDiv2 |=> s_div2)
      else $error("divide by two not kept");

   a_clkout_off: assert property (
      !s_ff.ctrl[B_MCO] |=> !clkOutO)
      else $error("clock out toggles while disabled");

   a_clkout_hold: assert property (
      (activeHalt && $past(activeHalt) && s_ff.ctrl[B_MCO])
         |-> $stable(clkOutO))
      else $error("clock out moves in active-halt");

   a_flag_set: assert property (
      tbEnd |=> s_ff.ctrl[B_OIF] && s_ff.tbCnt == '0)
      else $error("period end did not set flag");

   a_flag_rdclr: assert property (
      (rdClr && !tbEnd) |=> !s_ff.ctrl[B_OIF])
      else $error("read did not clear flag");

   a_sel_hold: assert property (
      !tbEnd |=> $stable(s_ff.tbSel))
      else $error("period setting changed mid-period");

   a_halt_entry: assert property (
      (s_ff.pm == PM_RUN && haltReq && oieNow) |=> activeHalt)
      else $error("halt did not enter active-halt");

   a_act_wake: assert property (
      (activeHalt && periodIrq) |=> s_ff.pm == PM_RUN)
      else $error("active-halt not left on interrupt");

   a_halt_frozen: assert property (
      fullHalt |=> $stable(s_ff.tbCnt) && $stable(s_ff.ctrl[B_OIF]))
      else $error("time base moved in full halt");

   a_tone_off: assert property (
      (s_ff.toneSel == TONE_OFF) |=> !toneO)
      else $error("tone active while off");

   a_clkout_run: assert property (
      (s_ff.ctrl[B_MCO] && s_ff.pm == PM_RUN && cpuClkEn) |=> $changed(clkOutO))
      else $error("clock out not toggling");

   a_sel_latch: assert property (
      tbEnd |=> s_ff.tbSel == $past(s_ff.ctrl[TB_LSB +: 2]))
      else $error("new period setting not taken at period end");

   a_cpu_halted: assert property (
      (s_ff.pm != PM_RUN) |=> !cpuClkEn)
      else $error("cpu enable active while halted");

   a_full_stay: assert property (
      (fullHalt && !wakeOther) |=> fullHalt)
      else $error("full halt left without other wake source");

   a_tone_flip: assert property (
      (s_ff.toneSel != TONE_OFF && s_ff.pm != PM_HALT &&
       s_ff.toneCnt >= toneLast(s_ff.toneSel)) |=> $changed(toneO))
      else $error("tone did not toggle at half period");

endmodule

`default_nettype wire

/* mcc_cpu_model.sv */
// Behavioural model of the CPU core, interrupt mask and power-mode logic
`timescale 1ns/100ps
`default_nettype none
module mcc_cpu_model (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic haltCmd,
   input  wire logic wakeCmd,
   input  wire logic maskCmd,
   output logic      haltReq,
   output logic      wakeOther,
   output logic      cpuIrqMask
);
   logic haltSeen;

   // Halt instruction gives one pulse per request
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         haltReq    <= 1'b0;
         haltSeen   <= 1'b0;
         wakeOther  <= 1'b0;
         cpuIrqMask <= 1'b0;
      end else begin
         haltReq    <= haltCmd & ~haltSeen;
         haltSeen   <= haltCmd;
         wakeOther  <= wakeCmd;
         cpuIrqMask <= maskCmd;
      end
   end
endmodule
`default_nettype wire

/* test_main_clock_rtc_controller.sv */
// Self-checking testbench of the main clock and time-base controller
`timescale 1ns/100ps
`default_nettype none
module test_main_clock_rtc_controller;
   import mcc_pkg::*;
   localparam int PER [4] = '{20, 30, 40, 50};
   localparam int HALF [4] = '{0, 3, 5, 7};
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        haltCmd = 1'b0;
   logic        wakeCmd = 1'b0;
   logic        maskCmd = 1'b0;
   logic        clkEn = 1'b1;
   apb_req_t    apbReq = '0;
   apb_rsp_t    apbRsp;
   logic        haltReq, wakeOther, cpuIrqMask, cpuClkEn, periodIrq, irq;
   logic        activeHalt, fullHalt, clkOutO, clkOutOe, toneO, toneOe;
   logic [31:0] rd;
   logic        se;
   int          errCount = 0;
   int          nTests = 0;
   int          cyc = 0;
   int          t0, t1, t2, n, m, c;

   main_clock_rtc_controller #(
      .TB_PERIOD0(PER[0]), .TB_PERIOD1(PER[1]), .TB_PERIOD2(PER[2]),
      .TB_PERIOD3(PER[3]), .TONE_HALF1(HALF[1]), .TONE_HALF2(HALF[2]),
      .TONE_HALF3(HALF[3])
   ) i_main_clock_rtc_controller (
      .mclk(mclk), .rstn(rstn), .clkEn(clkEn), .apbReq(apbReq),
      .apbRsp(apbRsp), .haltReq(haltReq), .wakeOther(wakeOther),
      .cpuIrqMask(cpuIrqMask), .cpuClkEn(cpuClkEn), .periodIrq(periodIrq),
      .irq(irq), .activeHalt(activeHalt), .fullHalt(fullHalt),
      .clkOutO(clkOutO), .clkOutOe(clkOutOe), .toneO(toneO),
      .toneOe(toneOe)
   );

   mcc_cpu_model i_mcc_cpu_model (
      .mclk(mclk), .rstn(rstn), .haltCmd(haltCmd), .wakeCmd(wakeCmd),
      .maskCmd(maskCmd), .haltReq(haltReq), .wakeOther(wakeOther),
      .cpuIrqMask(cpuIrqMask)
   );

   always #20 mclk = ~mclk;

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         errCount++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      nTests++;
      if (got !== ex) begin
         errCount++;
         $display("BAD %s expected %0h seen %0h", nm, ex, got);
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
      @(posedge mclk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr,
                  paddr: {idx, 2'b00}, pwdata: wd};
      @(posedge mclk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata;
      se = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask

   // Waits for the period event, then clears it by a read
   task automatic waitIrq(output int t);
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (periodIrq !== 1'b1 && k < 400);
      t = cyc;
      xfer(1'b0, IDX_CTRL, 32'h0);
      chk("flagSet", 32'h1, {31'h0, rd[0]});
   endtask

   task automatic cnt(input int st, input int len, output int ce,
                      output int co);
      logic p;
      repeat (st) @(posedge mclk);
      ce = 0;
      co = 0;
      p = clkOutO;
      repeat (len) begin
         @(posedge mclk);
         ce += int'(cpuClkEn === 1'b1);
         co += int'(clkOutO !== p);
         p = clkOutO;
      end
   endtask

   task automatic gap(output int g);
      logic p;
      int k;
      k = 0;
      @(posedge mclk);
      p = toneO;
      do begin
         @(posedge mclk);
         k++;
      end while (toneO === p && k < 100);
      p = toneO;
      g = 0;
      do begin
         @(posedge mclk);
         g++;
      end while (toneO === p && g < 100);
   endtask

   task automatic pulse(input logic wake);
      @(posedge mclk);
      if (wake) begin
         wakeCmd <= 1'b1;
      end else begin
         haltCmd <= 1'b1;
      end
      @(posedge mclk);
      wakeCmd <= 1'b0;
      haltCmd <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   initial begin
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      xfer(1'b0, IDX_CTRL, 32'h0);
      chk("ctrlReset", 32'h0, rd);
      xfer(1'b0, IDX_TONE, 32'h0);
      chk("toneReset", 32'h0, rd);
      xfer(1'b0, 8'h3F, 32'h0);
      chk("unmapped", 32'h1, {31'h0, se});
      $display("reset test done");
      for (c = 0; c < 5; c++) begin
         xfer(1'b1, IDX_CTRL, (c < 4) ? 32'h90 | (c << 5) : 32'h80);
         cnt(8, 32, n, m);
         t0 = (c < 4) ? 32 >> (c + 1) : 32;
         chk("cpuClk", t0, n);
         chk("clkOut", t0, m);
         chk("clkOutOe", 32'h1, {31'h0, clkOutOe});
      end
      clkEn <= 1'b0;
      cnt(1, 8, n, m);
      clkEn <= 1'b1;
      chk("clkEnFreeze", 32'h0, m);
      xfer(1'b1, IDX_CTRL, 32'h0);
      cnt(8, 32, n, m);
      chk("clkOutOff", 32'h0, m);
      chk("clkOutOeOff", 32'h0, {31'h0, clkOutOe});
      $display("clock test done");
      for (c = 1; c < 4; c++) begin
         xfer(1'b1, IDX_TONE, c);
         gap(n);
         chk("toneHalf", HALF[c], n);
         chk("toneOe", 32'h1, {31'h0, toneOe});
      end
      xfer(1'b1, IDX_TONE, 32'h0);
      @(posedge mclk);
      chk("toneOff", 32'h0, {31'h0, toneOe});
      $display("tone test done");
      xfer(1'b1, IDX_CTRL, 32'h2);
      waitIrq(t0);
      waitIrq(t0);
      for (c = 1; c < 4; c++) begin
         xfer(1'b1, IDX_CTRL, 32'h2 | (c << 2));
         waitIrq(t1);
         chk("oldPeriod", PER[c - 1], t1 - t0);
         waitIrq(t2);
         chk("newPeriod", PER[c], t2 - t1);
         t0 = t2;
      end
      xfer(1'b1, IDX_IRQ_MSK, 32'h1);
      @(posedge mclk);
      chk("irqSet", 32'h1, {31'h0, irq});
      xfer(1'b1, IDX_IRQ_ST, 32'h1);
      @(posedge mclk);
      chk("irqClear", 32'h0, {31'h0, irq});
      maskCmd <= 1'b1;
      repeat (60) @(posedge mclk);
      chk("cpuMasked", 32'h0, {31'h0, periodIrq});
      xfer(1'b0, IDX_CTRL, 32'h0);
      chk("flagHeld", 32'h1, {31'h0, rd[0]});
      maskCmd <= 1'b0;
      $display("time-base test done");
      xfer(1'b1, IDX_CTRL, 32'h86);
      waitIrq(t1);
      waitIrq(t1);
      pulse(1'b0);
      chk("actHalt", 32'h1, {31'h0, activeHalt});
      cnt(0, 8, n, m);
      chk("haltClkOut", 32'h0, m);
      chk("haltCpuClk", 32'h0, n);
      xfer(1'b1, IDX_CTRL, 32'h0);
      n = 0;
      while (activeHalt === 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      chk("actWake", 32'h0, {31'h0, activeHalt});
      xfer(1'b0, IDX_CTRL, 32'h0);
      chk("frozenRegs", 32'h87, rd);
      xfer(1'b1, IDX_CTRL, 32'h6);
      waitIrq(t1);
      xfer(1'b1, IDX_CTRL, 32'h4);
      pulse(1'b0);
      chk("fullHalt", 32'h1, {31'h0, fullHalt});
      repeat (100) @(posedge mclk);
      chk("stayHalt", 32'h1, {31'h0, fullHalt});
      pulse(1'b1);
      chk("fullWake", 32'h0, {31'h0, fullHalt});
      xfer(1'b0, IDX_CTRL, 32'h0);
      chk("counterFrozen", 32'h4, rd);
      $display("power test done");
      complete_run();
   end
endmodule
`default_nettype wire
